// ===== clock_route_regs.svh
`ifndef CLOCK_ROUTE_REGS_SVH
`define CLOCK_ROUTE_REGS_SVH

// ==========================================================
// register offsets
`define ROUTE_OFFSET      8'h03
`define SPREAD_OFFSET     8'h04

// ==========================================================
// reset values
`define ROUTE_RESET       16'h1801
`define SPREAD_RESET      16'h0000

// ==========================================================
// routing register field positions
`define FRAC_B_INT_MSB    15
`define FRAC_B_INT_LSB    9
`define CHAN_B_SRC_BIT    8
`define DRV_B_COMB_BIT    7
`define DRV_B_OFF_BIT     6
`define DRV_A_OFF_BIT     5
`define CHAN_A_SRC_BIT    4
`define DRV_A_COMB_BIT    3
`define CHAN_A_RATIO_MSB  2
`define CHAN_A_RATIO_LSB  0

// ==========================================================
// spread register field positions
`define SPREAD_RSVD_BIT   15
`define STEP_COUNT_MSB    14
`define STEP_COUNT_LSB    2
`define SPREAD_TYPE_BIT   1
`define SPREAD_EN_BIT     0

// ==========================================================
// timing counts
`define READ_LATENCY      1

`endif

// ===== clock_route_pkg.sv
package clock_route_pkg;

    // ==========================================================
    // channel divider ratio codes
    typedef enum logic [2:0] {
        RATIO_OFF = 3'h0,
        RATIO_2   = 3'h1,
        RATIO_4   = 3'h2,
        RATIO_6   = 3'h3,
        RATIO_8   = 3'h4,
        RATIO_10  = 3'h5,
        RATIO_20  = 3'h6,
        RATIO_40  = 3'h7
    } ratio_t;

    // source selection of a channel divider
    typedef enum logic {
        SRC_FRAC_A = 1'b0,
        SRC_FRAC_B = 1'b1
    } source_t;

    // disabled pin behaviour
    typedef enum logic {
        OFF_GROUND   = 1'b0,
        OFF_TRISTATE = 1'b1
    } off_mode_t;

endpackage

// ===== chan_div_if.sv
interface chan_div_if;
    import clock_route_pkg::*;
    source_t srcSel;
    ratio_t  ratio;
    logic    tickA;
    logic    tickB;
    logic    divOut;

    // ==========================================================
    // control side and divider side
    modport ctrl (output srcSel, output ratio, output tickA, output tickB, input divOut);
    modport div  (input srcSel, input ratio, input tickA, input tickB, output divOut);
endinterface

// ===== chan_divider.sv
module chan_divider
    import clock_route_pkg::*;
#(
    parameter int COUNT_WIDTH = 5
) (
    input wire logic     clock,
    input wire logic     rst,
    chan_div_if.div      port
);

    // ==========================================================
    // elaboration check
    initial begin
        if (COUNT_WIDTH < 5) begin
            $error("COUNT_WIDTH too small for a half period of 20 ticks");
        end
    end

    // half period in source ticks for a ratio code
    function automatic logic [COUNT_WIDTH-1:0] halfTicks(input ratio_t r);
        case (r)
            RATIO_2:  halfTicks = COUNT_WIDTH'(1);
            RATIO_4:  halfTicks = COUNT_WIDTH'(2);
            RATIO_6:  halfTicks = COUNT_WIDTH'(3);
            RATIO_8:  halfTicks = COUNT_WIDTH'(4);
            RATIO_10: halfTicks = COUNT_WIDTH'(5);
            RATIO_20: halfTicks = COUNT_WIDTH'(10);
            RATIO_40: halfTicks = COUNT_WIDTH'(20);
            default:  halfTicks = COUNT_WIDTH'(0);
        endcase
    endfunction

    logic [COUNT_WIDTH-1:0] count;
    logic [COUNT_WIDTH-1:0] next_count;
    logic                   divOut;
    logic                   next_divOut;
    source_t                curSel;
    source_t                next_curSel;
    ratio_t                 curRatio;
    ratio_t                 next_curRatio;
    logic                   tick;

    // ==========================================================
    // divider next state, new settings taken only at a low phase
    always_comb begin
        tick          = (curSel == SRC_FRAC_B) ? port.tickB : port.tickA;
        next_count    = count;
        next_divOut   = divOut;
        next_curSel   = curSel;
        next_curRatio = curRatio;
        if (curRatio == RATIO_OFF) begin
            next_count    = '0;
            next_divOut   = 1'b0;
            next_curSel   = port.srcSel;         // [R2] [R6]
            next_curRatio = port.ratio;          // [R8] [R16]
        end else if (tick) begin
            if (count == halfTicks(curRatio) - COUNT_WIDTH'(1)) begin
                next_count  = '0;
                next_divOut = ~divOut;
                if (divOut) begin
                    next_curSel   = port.srcSel; // [R16]
                    next_curRatio = port.ratio;
                end
            end else begin
                next_count = count + COUNT_WIDTH'(1);
            end
        end
    end

    // divider registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count    <= '0;
            divOut   <= 1'b0;
            curSel   <= SRC_FRAC_A;
            curRatio <= RATIO_OFF;
        end else begin
            count    <= next_count;
            divOut   <= next_divOut;
            curSel   <= next_curSel;
            curRatio <= next_curRatio;
        end
    end

    assign port.divOut = divOut;

    // ==========================================================
    // checks
    a_glitch_free_load: assert property (@(posedge clock) disable iff (rst) // [R16]
        (curRatio != $past(curRatio)) |-> !divOut)
        else $error("divider ratio changed during a high phase");
    a_off_holds_low: assert property (@(posedge clock) disable iff (rst) // [R8]
        (curRatio == RATIO_OFF) |=> !divOut)
        else $error("disabled divider produced a high output");

endmodule

// ===== clock_route_ssc_config.sv
// Behaviour
// [R1] routing bits 15:9 hold divider-b integer ratio
// [R2] bit 8 picks channel b source
// [R3] bit 7 routes driver b from combiner
// [R4] bit 6 sets driver b disabled pins
// [R5] bit 5 sets driver a disabled pins
// [R6] bit 4 picks channel a source
// [R7] bit 3 routes driver a from combiner
// [R8] bits 2:0 set channel a ratio
// [R9] software zeroes ratio when using combiner
// [R10] spread bits 14:2 hold step count
// [R11] bit 1 selects down or center spread
// [R12] bit 0 enables spread spectrum, reset zero
// [R13] software never writes spread bit 15
// [R14] fuse copy loads every field's default; a host write to a register in the same cycle keeps that register instead
// [R15] routing register resets to 0x1801
// [R16] divider changes produce no runt pulses
`include "clock_route_regs.svh"

module clock_route_ssc_config
    import clock_route_pkg::*;
#(
    parameter int ADDR_WIDTH = 8
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [ADDR_WIDTH-1:0] regAddr,
    input  wire logic                  regWrite,
    input  wire logic [15:0]           regWriteData,
    input  wire logic                  regRead,
    output logic      [15:0]           regReadData,
    input  wire logic                  fuseLoad,
    input  wire logic [15:0]           fuseRouting,
    input  wire logic [15:0]           fuseSpread,
    input  wire logic                  fracTickA,
    input  wire logic                  fracTickB,
    input  wire logic                  combinerClock,
    input  wire logic [2:0]            chanBRatio,
    input  wire logic                  outputAEnable,
    input  wire logic                  outputBEnable,
    output logic                       outputATruePin,
    output logic                       outputACompPin,
    output logic                       outputAPinOe,
    output logic                       outputBTruePin,
    output logic                       outputBCompPin,
    output logic                       outputBPinOe,
    output logic      [6:0]            fracDivBInteger,
    output logic      [12:0]           spreadStepCount,
    output logic                       spreadProfileType,
    output logic                       spreadEnable
);

    // ==========================================================
    // elaboration check
    initial begin
        if (ADDR_WIDTH < 3) begin
            $error("ADDR_WIDTH cannot reach the register offsets");
        end
    end

    localparam logic [ADDR_WIDTH-1:0] ROUTE_ADDR  = ADDR_WIDTH'(`ROUTE_OFFSET);
    localparam logic [ADDR_WIDTH-1:0] SPREAD_ADDR = ADDR_WIDTH'(`SPREAD_OFFSET);

    logic [15:0] routing;
    logic [15:0] next_routing;
    logic [14:0] spread;
    logic [14:0] next_spread;
    logic [15:0] next_regReadData;

    // ==========================================================
    // register file next values; a host write wins over a fuse load
    always_comb begin
        next_routing     = routing;
        next_spread      = spread;
        next_regReadData = regReadData;
        if (fuseLoad) begin
            next_routing = fuseRouting;                       // [R14]
            next_spread  = fuseSpread[`STEP_COUNT_MSB:0];     // [R14]
        end
        if (regWrite && regAddr == ROUTE_ADDR) begin
            next_routing = regWriteData;                      // [R1] [R8]
        end
        if (regWrite && regAddr == SPREAD_ADDR) begin
            next_spread = regWriteData[`STEP_COUNT_MSB:0];    // [R10] [R11] [R12]
        end
        if (regRead) begin
            case (regAddr)
                ROUTE_ADDR:  next_regReadData = routing;
                SPREAD_ADDR: next_regReadData = {1'b0, spread}; // reserved bit reads zero
                default:     next_regReadData = 16'h0000;
            endcase
        end
    end

    // register file
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            routing     <= `ROUTE_RESET;                       // [R15]
            spread      <= 15'h0000;                           // [R12]
            regReadData <= 16'h0000;
        end else begin
            routing     <= next_routing;
            spread      <= next_spread;
            regReadData <= next_regReadData;
        end
    end

    // ==========================================================
    // configuration outputs straight from the register file
    assign fracDivBInteger   = routing[`FRAC_B_INT_MSB:`FRAC_B_INT_LSB]; // [R1]
    assign spreadStepCount   = spread[`STEP_COUNT_MSB:`STEP_COUNT_LSB];   // [R10]
    assign spreadProfileType = spread[`SPREAD_TYPE_BIT];                  // [R11]
    assign spreadEnable      = spread[`SPREAD_EN_BIT];                    // [R12]

    // ==========================================================
    // channel dividers and output drivers
    chan_div_if chanPort [2] ();

    logic [1:0] driveEnable;
    logic [1:0] combinerSel;
    logic [1:0] offMode;
    logic [1:0] truePin;
    logic [1:0] next_truePin;
    logic [1:0] compPin;
    logic [1:0] next_compPin;
    logic [1:0] pinOe;
    logic [1:0] next_pinOe;

    assign driveEnable = {outputBEnable, outputAEnable};
    assign combinerSel = {routing[`DRV_B_COMB_BIT], routing[`DRV_A_COMB_BIT]}; // [R3] [R7]
    assign offMode     = {routing[`DRV_B_OFF_BIT], routing[`DRV_A_OFF_BIT]};   // [R4] [R5]

    // channel divider settings
    assign chanPort[0].srcSel = source_t'(routing[`CHAN_A_SRC_BIT]);          // [R6]
    assign chanPort[0].ratio  = ratio_t'(routing[`CHAN_A_RATIO_MSB:`CHAN_A_RATIO_LSB]); // [R8]
    assign chanPort[1].srcSel = source_t'(routing[`CHAN_B_SRC_BIT]);          // [R2]
    assign chanPort[1].ratio  = ratio_t'(chanBRatio);

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic src;

            assign chanPort[ch].tickA = fracTickA;
            assign chanPort[ch].tickB = fracTickB;

            chan_divider #(
                .COUNT_WIDTH (5)
            ) divider (
                .clock (clock),
                .rst   (rst),
                .port  (chanPort[ch])
            );

            // driver pin next values
            always_comb begin
                src = combinerSel[ch] ? combinerClock : chanPort[ch].divOut; // [R3] [R7]
                if (driveEnable[ch]) begin
                    next_truePin[ch] = src;
                    next_compPin[ch] = ~src;
                    next_pinOe[ch]   = 1'b1;
                end else begin
                    next_truePin[ch] = 1'b0;
                    next_compPin[ch] = 1'b0;
                    next_pinOe[ch]   = (offMode[ch] == OFF_GROUND); // [R4] [R5]
                end
            end

            // driver pin registers
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    truePin[ch] <= 1'b0;
                    compPin[ch] <= 1'b0;
                    pinOe[ch]   <= 1'b1;
                end else begin
                    truePin[ch] <= next_truePin[ch];
                    compPin[ch] <= next_compPin[ch];
                    pinOe[ch]   <= next_pinOe[ch];
                end
            end
        end
    endgenerate

    assign outputATruePin = truePin[0];
    assign outputACompPin = compPin[0];
    assign outputAPinOe   = pinOe[0];
    assign outputBTruePin = truePin[1];
    assign outputBCompPin = compPin[1];
    assign outputBPinOe   = pinOe[1];

    // ==========================================================
    // checks
    sequence s_route_write;
        regWrite && regAddr == ROUTE_ADDR;
    endsequence

    sequence s_spread_write;
        regWrite && regAddr == SPREAD_ADDR;
    endsequence

    a_route_write: assert property (@(posedge clock) disable iff (rst) // [R1]
        s_route_write |=> (routing == $past(regWriteData) && fracDivBInteger == $past(regWriteData[15:9])))
        else $error("routing write not stored");
    a_spread_write: assert property (@(posedge clock) disable iff (rst) // [R10]
        s_spread_write |=> (spreadStepCount == $past(regWriteData[14:2])
                            && spreadEnable == $past(regWriteData[0])
                            && spreadProfileType == $past(regWriteData[1])))
        else $error("spread write not stored");
    a_reserved_zero: assert property (@(posedge clock) disable iff (rst) // [R13]
        (regRead && regAddr == SPREAD_ADDR) |=> (regReadData[15] == 1'b0))
        else $error("reserved spread bit read as one");
    a_route_read: assert property (@(posedge clock) disable iff (rst) // [R15]
        (regRead && regAddr == ROUTE_ADDR) |=> (regReadData == $past(routing)))
        else $error("routing read returned wrong value");
    a_fuse_default: assert property (@(posedge clock) disable iff (rst) // [R14]
        (fuseLoad && !regWrite) |=> (routing == $past(fuseRouting)))
        else $error("fuse default not loaded");
    a_off_ground: assert property (@(posedge clock) disable iff (rst) // [R5]
        (!outputAEnable && !routing[`DRV_A_OFF_BIT]) |=> (outputAPinOe && !outputATruePin && !outputACompPin))
        else $error("output a not grounded while off");
    a_off_tristate: assert property (@(posedge clock) disable iff (rst) // [R4]
        (!outputBEnable && routing[`DRV_B_OFF_BIT]) |=> !outputBPinOe)
        else $error("output b still driven while off");
    a_comb_route: assert property (@(posedge clock) disable iff (rst) // [R7]
        (outputAEnable && routing[`DRV_A_COMB_BIT]) |=> (outputATruePin == $past(combinerClock)
                                                      && outputACompPin == !$past(combinerClock)))
        else $error("output a not following the edge combiner");

endmodule

// ===== clock_route_ssc_config_tb.sv
`include "clock_route_regs.svh"

module clock_route_ssc_config_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import clock_route_pkg::*;

    // ==========================================================
    // stimulus and observed signals
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic        regWrite = 1'b0;
    logic [15:0] regWriteData = 16'h0000;
    logic        regRead = 1'b0;
    logic [15:0] regReadData;
    logic        fuseLoad = 1'b0;
    logic [15:0] fuseRouting = 16'h0000;
    logic [15:0] fuseSpread = 16'h0000;
    logic        fracTickA = 1'b1;
    logic        fracTickB = 1'b0;
    logic        combinerClock = 1'b0;
    logic [2:0]  chanBRatio = 3'h0;
    logic        outputAEnable = 1'b1;
    logic        outputBEnable = 1'b1;
    logic        outputATruePin, outputACompPin, outputAPinOe;
    logic        outputBTruePin, outputBCompPin, outputBPinOe;
    logic [6:0]  fracDivBInteger;
    logic [12:0] spreadStepCount;
    logic        spreadProfileType;
    logic        spreadEnable;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          cycles = 0;

    clock_route_ssc_config u_dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrite(regWrite),
        .regWriteData(regWriteData), .regRead(regRead), .regReadData(regReadData), .fuseLoad(fuseLoad),
        .fuseRouting(fuseRouting), .fuseSpread(fuseSpread), .fracTickA(fracTickA), .fracTickB(fracTickB),
        .combinerClock(combinerClock), .chanBRatio(chanBRatio), .outputAEnable(outputAEnable),
        .outputBEnable(outputBEnable), .outputATruePin(outputATruePin), .outputACompPin(outputACompPin),
        .outputAPinOe(outputAPinOe), .outputBTruePin(outputBTruePin), .outputBCompPin(outputBCompPin),
        .outputBPinOe(outputBPinOe), .fracDivBInteger(fracDivBInteger), .spreadStepCount(spreadStepCount),
        .spreadProfileType(spreadProfileType), .spreadEnable(spreadEnable));

    // ==========================================================
    // clock, half-rate tick for source b, and hang guard
    always #50 clock = ~clock;

    always @(posedge clock) begin
        fracTickB <= #1 ~fracTickB;
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            error_cnt = error_cnt + 1;
            results();
        end
    end

    // ==========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        regAddr = a;
        regWriteData = d;
        regWrite = 1'b1;
        tick(1);
        regWrite = 1'b0;
        // idle edge so a following transfer never re-raises the strobe at once
        tick(1);
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [15:0] exp, input string name);
        regAddr = a;
        regRead = 1'b1;
        tick(1);
        regRead = 1'b0;
        check(name, regReadData, exp);
        tick(1);
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic reset_values();
        rst = 1'b1;
        tick(6);
        rst = 1'b0;
        rd_check(`ROUTE_OFFSET, 16'h1801, "routing reset");
        rd_check(`SPREAD_OFFSET, 16'h0000, "spread reset");
        check("ratio b integer", {9'h0, fracDivBInteger}, 16'h000c);
        check("spread outputs", {2'h0, spreadStepCount, spreadEnable}, 16'h0000);
    endtask

    task automatic field_access();
        wr(`ROUTE_OFFSET, 16'ha5a6);
        rd_check(`ROUTE_OFFSET, 16'ha5a6, "routing rw");
        check("ratio b integer", {9'h0, fracDivBInteger}, 16'h0052);
        wr(`SPREAD_OFFSET, 16'h7fff);
        rd_check(`SPREAD_OFFSET, 16'h7fff, "spread rw");
        check("step count", {3'h0, spreadStepCount}, 16'h1fff);
        check("type enable", {14'h0, spreadProfileType, spreadEnable}, 16'h0003);
        wr(`SPREAD_OFFSET, 16'h0002);
        check("type only", {14'h0, spreadProfileType, spreadEnable}, 16'h0002);
        wr(8'h05, 16'hffff);
        rd_check(8'h05, 16'h0000, "unmapped read");
        rd_check(`ROUTE_OFFSET, 16'ha5a6, "unmapped write");
    endtask

    task automatic fuse_defaults();
        fuseRouting = 16'h3c59;
        fuseSpread = 16'hd2b5;
        fuseLoad = 1'b1;
        tick(1);
        fuseLoad = 1'b0;
        rd_check(`ROUTE_OFFSET, 16'h3c59, "fuse routing");
        rd_check(`SPREAD_OFFSET, 16'h52b5, "fuse spread");
        // host write and fuse load together: the write keeps its register
        regAddr = `ROUTE_OFFSET;
        regWriteData = 16'h1801;
        regWrite = 1'b1;
        fuseLoad = 1'b1;
        tick(1);
        regWrite = 1'b0;
        fuseLoad = 1'b0;
        tick(1);
        rd_check(`ROUTE_OFFSET, 16'h1801, "write over fuse");
        rd_check(`SPREAD_OFFSET, 16'h52b5, "fuse spread kept");
    endtask

    task automatic disabled_pins();
        for (int m = 0; m < 2; m++) begin
            wr(`ROUTE_OFFSET, 16'h1801 | (16'(m) << 6) | (16'(m) << 5));
            outputAEnable = 1'b0;
            outputBEnable = 1'b0;
            tick(2);
            check("pins a off", {13'h0, outputATruePin, outputACompPin, outputAPinOe}, 16'(1 - m));
            check("pins b off", {13'h0, outputBTruePin, outputBCompPin, outputBPinOe}, 16'(1 - m));
            outputAEnable = 1'b1;
            outputBEnable = 1'b1;
        end
    endtask

    task automatic combiner_route();
        wr(`ROUTE_OFFSET, 16'h1888);
        for (int i = 0; i < 6; i++) begin
            combinerClock = i[0] ^ i[1];
            tick(1);
            check("comb a", {14'h0, outputATruePin, outputACompPin}, {14'h0, combinerClock, ~combinerClock});
            check("comb b", {14'h0, outputBTruePin, outputBCompPin}, {14'h0, combinerClock, ~combinerClock});
            check("comb oe", {14'h0, outputAPinOe, outputBPinOe}, 16'h0003);
        end
    endtask

    // cycles between rising edges of the chosen true pin
    task automatic period(input logic useB, input int exp, input string name);
        int n;
        logic prev;
        tick(200);
        for (n = 0; n < 200; n++) begin
            prev = useB ? outputBTruePin : outputATruePin;
            tick(1);
            if (!prev && (useB ? outputBTruePin : outputATruePin))
                break;
        end
        for (n = 1; n < 200; n++) begin
            prev = useB ? outputBTruePin : outputATruePin;
            tick(1);
            if (!prev && (useB ? outputBTruePin : outputATruePin))
                break;
        end
        check(name, 16'(n), 16'(exp));
    endtask

    task automatic divider_ratios();
        int div[8] = '{0, 2, 4, 6, 8, 10, 20, 40};
        for (int c = 1; c < 8; c++) begin
            wr(`ROUTE_OFFSET, 16'h1800 | 16'(c));
            period(1'b0, div[c], "ratio a frac a");
        end
        wr(`ROUTE_OFFSET, 16'h1813);
        period(1'b0, 12, "ratio a frac b");
        chanBRatio = 3'h3;
        period(1'b1, 6, "ratio b frac a");
        wr(`ROUTE_OFFSET, 16'h1903);
        period(1'b1, 12, "ratio b frac b");
    endtask

    // ==========================================================
    // main sequence
    initial begin
        reset_values();
        field_access();
        fuse_defaults();
        disabled_pins();
        combiner_route();
        divider_ratios();
        reset_values();
        results();
    end
endmodule
